// file: verilog/cpt_pkg.sv
package cpt_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CPT_CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] CPT_RELOAD0_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] CPT_RELOAD1_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] CPT_COUNT0_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] CPT_COUNT1_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] CPT_IRQ_STAT_OFS = 8'h14;
	localparam logic [ADDR_W-1:0] CPT_IRQ_MASK_OFS = 8'h18;
	localparam logic [ADDR_W-1:0] CPT_STATUS_OFS = 8'h1C;

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	localparam int CTRL_RUN0_BIT = 0;
	localparam int CTRL_RUN1_BIT = 1;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_W = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	typedef enum logic [1:0] {
		CPT_MODE_PERIODIC,
		CPT_MODE_EVENT,
		CPT_MODE_ONESHOT
	} cpt_mode_t;

	// ----------------------------------------
	// timing of the documented arrangements
	// ----------------------------------------
	localparam int EXAMPLE_CLOCK_HZ = 16_000_000;
	localparam int TICK_US = 1000;
	localparam int PWM_HIGH_US = 500;
	localparam int SECOND_MS = 1000;
	localparam int TICK_CYCLES = EXAMPLE_CLOCK_HZ / 1_000_000 * TICK_US;
	localparam int PWM_HIGH_CYCLES = EXAMPLE_CLOCK_HZ / 1_000_000 * PWM_HIGH_US;
	localparam logic [15:0] RELOAD0_RESET = 16'(TICK_CYCLES - 1);
	localparam logic [15:0] RELOAD1_RESET = 16'(SECOND_MS - 1);
	localparam logic [15:0] PWM_HIGH_RELOAD = 16'(PWM_HIGH_CYCLES - 1);

endpackage

// file: verilog/cpt_down_counter.sv
`timescale 1ns/1ps
module cpt_down_counter #(
	parameter int WIDTH = 16
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_load,
	input wire logic i_tick,
	input wire logic [WIDTH-1:0] i_reload,
	output logic [WIDTH-1:0] o_count,
	output logic o_underflow
);

	generate
		if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
			$error("counter width must lie in 2..32");
		end
	endgenerate

	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] count_d;
	wire at_zero = (count_q == '0);

	// underflow is the tick that finds zero; a load hides it
	assign o_underflow = i_tick && at_zero && !i_load;
	assign o_count = count_q;

	// zero is a real state, so n counts down in n plus one ticks
	assign count_d = i_load ? i_reload :
		o_underflow ? i_reload :
		i_tick ? count_q - 1'b1 : count_q;

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

endmodule // cpt_down_counter

// file: verilog/cpt_timer_pair.sv
`timescale 1ns/1ps
module cpt_timer_pair #(
	parameter int WIDTH = 16
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic [cpt_pkg::ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [31:0] o_rdata,
	output logic o_irq,
	output logic o_second_timer_pulse_out
);
	import cpt_pkg::*;

	generate
		if (WIDTH < 2 || WIDTH > 16) begin : g_bad_width
			$error("timer width must lie in 2..16");
		end
	endgenerate

	// ----------------------------------------
	// registers
	// ----------------------------------------

	logic [CTRL_W-1:0] ctrl_q;
	logic [WIDTH-1:0] reload0_q;
	logic [WIDTH-1:0] reload1_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_stat_d;
	logic [1:0] irq_mask_q;
	logic busy_q;
	logic busy_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	wire [WIDTH-1:0] count0;
	wire [WIDTH-1:0] count1;
	wire uf0;
	wire uf1;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------

	// one strobe per cycle; writes to unmapped offsets vanish
	wire wr_ctrl = i_write && (i_addr == CPT_CTRL_OFS);
	wire wr_rel0 = i_write && (i_addr == CPT_RELOAD0_OFS);
	wire wr_rel1 = i_write && (i_addr == CPT_RELOAD1_OFS);
	wire wr_stat = i_write && (i_addr == CPT_IRQ_STAT_OFS);
	wire wr_mask = i_write && (i_addr == CPT_IRQ_MASK_OFS);

	// ----------------------------------------
	// control decode
	// ----------------------------------------

	wire run0 = ctrl_q[CTRL_RUN0_BIT];
	wire run1 = ctrl_q[CTRL_RUN1_BIT];
	wire [1:0] mode_bits = ctrl_q[CTRL_MODE_LSB +: 2];
	wire mode_event = (mode_bits == CPT_MODE_EVENT);
	wire mode_oneshot = (mode_bits == CPT_MODE_ONESHOT);
	// the reserved fourth mode code acts as periodic
	wire mode_periodic = !mode_event && !mode_oneshot;

	// ----------------------------------------
	// first timer
	// ----------------------------------------

	// count source is the bare system clock, no prescale
	wire tick0 = run0;
	// a stopped timer sits on its reload so a start begins at n
	wire load0 = !run0;

	cpt_down_counter #(
		.WIDTH(WIDTH)
	) u_timer0 (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_load(load0),
		.i_tick(tick0),
		.i_reload(reload0_q),
		.o_count(count0),
		.o_underflow(uf0)
	);

	// ----------------------------------------
	// second timer
	// ----------------------------------------

	// one-shot trigger: armed, idle, and the first timer underflows
	wire trigger1 = mode_oneshot && run1 && !busy_q && uf0;

	// periodic counts clocks, event counts first-timer underflows
	wire tick1 = mode_periodic ? run1 :
		mode_event ? (run1 && uf0) :
		busy_q;

	// clearing the start flag aborts any shot in flight
	wire load1 = !run1;

	cpt_down_counter #(
		.WIDTH(WIDTH)
	) u_timer1 (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_load(load1),
		.i_tick(tick1),
		.i_reload(reload1_q),
		.o_count(count1),
		.o_underflow(uf1)
	);

	// ----------------------------------------
	// one-shot pulse
	// ----------------------------------------

	// a trigger during a shot is ignored rather than restarting it
	assign busy_d = trigger1 ? 1'b1 :
		(uf1 || load1 || !mode_oneshot) ? 1'b0 :
		busy_q;

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
		end
	end

	// the pin follows a flop, so it is glitch free
	assign o_second_timer_pulse_out = busy_q;

	// ----------------------------------------
	// interrupt flags
	// ----------------------------------------

	// hardware set wins over a write-one clear in the same cycle
	wire [1:0] irq_set = {uf1, uf0};
	wire [1:0] irq_clr = wr_stat ? i_wdata[1:0] : 2'h0;
	assign irq_stat_d = irq_set | (irq_stat_q & ~irq_clr);

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_stat_q <= IRQ_RESET;
		end else begin
			irq_stat_q <= irq_stat_d;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_mask_q <= IRQ_RESET;
		end else if (wr_mask) begin
			irq_mask_q <= i_wdata[1:0];
		end
	end

	assign o_irq = |(irq_stat_q & irq_mask_q);

	// ----------------------------------------
	// software registers
	// ----------------------------------------

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= i_wdata[CTRL_W-1:0];
		end
	end

	// defaults give the 1 ms tick and the one-second interval at 16 MHz
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			reload0_q <= RELOAD0_RESET[WIDTH-1:0];
		end else if (wr_rel0) begin
			reload0_q <= i_wdata[WIDTH-1:0];
		end
	end

	// a new reload takes effect at the next underflow, or at once while the second timer is stopped
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			reload1_q <= RELOAD1_RESET[WIDTH-1:0];
		end else if (wr_rel1) begin
			reload1_q <= i_wdata[WIDTH-1:0];
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------

	// read data stand for exactly one cycle, zero otherwise
	always_comb begin
		rdata_d = 32'h0;
		if (i_read) begin
			case (i_addr)
				CPT_CTRL_OFS: rdata_d = 32'(ctrl_q);
				CPT_RELOAD0_OFS: rdata_d = 32'(reload0_q);
				CPT_RELOAD1_OFS: rdata_d = 32'(reload1_q);
				CPT_COUNT0_OFS: rdata_d = 32'(count0);
				CPT_COUNT1_OFS: rdata_d = 32'(count1);
				CPT_IRQ_STAT_OFS: rdata_d = 32'(irq_stat_q);
				CPT_IRQ_MASK_OFS: rdata_d = 32'(irq_mask_q);
				CPT_STATUS_OFS: rdata_d = 32'(busy_q);
				default: rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------

	wire [WIDTH-1:0] count0_dec = count0 - 1'b1;
	wire [WIDTH-1:0] count1_dec = count1 - 1'b1;

	// a running first timer steps down once per clock
	count_step_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		run0 && (count0 != '0) |=> count0 == $past(count0_dec)
	) else $error("first timer did not decrement");

	// underflow reloads and the first flag rises
	reload0_irq_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		uf0 |=> (count0 == $past(reload0_q)) && irq_stat_q[0] && (run0 || $past(wr_ctrl))
	) else $error("first timer underflow mishandled");

	// event mode holds still between first-timer underflows
	event_hold_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		mode_event && run1 && !uf0 |=> $stable(count1)
	) else $error("event counter moved without an event");

	// each event steps the second timer once
	event_step_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		mode_event && run1 && uf0 && (count1 != '0)
		|=> count1 == $past(count1_dec)
	) else $error("event counter missed an event");

	// event underflow reloads and flags
	event_reload_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		mode_event && uf1 |=> (count1 == $past(reload1_q)) && irq_stat_q[1]
	) else $error("event counter underflow mishandled");

	// trigger raises the pin on the next edge
	pulse_rise_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		trigger1 |=> o_second_timer_pulse_out && (count1 == $past(reload1_q))
	) else $error("one-shot did not start");

	// end of shot: pin low, reloaded, stopped, flagged
	pulse_fall_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		busy_q && uf1 && !trigger1
		|=> !o_second_timer_pulse_out && irq_stat_q[1]
		##1 (count1 == $past(count1)) && (!o_second_timer_pulse_out || $past(trigger1))
	) else $error("one-shot did not end cleanly");

	// an event in the clearing cycle survives the clear
	set_wins_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		uf0 && wr_stat && i_wdata[0] |=> irq_stat_q[0]
	) else $error("flag lost to a clear");

	// a counter read shows the count of the read cycle, one cycle late
	count_read_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		i_read && (i_addr == CPT_COUNT0_OFS) |=> o_rdata == 32'($past(count0))
	) else $error("count read back wrong");

	// a stopped first timer keeps following its reload
	stop_follow_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		!run0 |=> count0 == $past(reload0_q)
	) else $error("stopped first timer left its reload");

	// a raised first flag stays up until software clears it
	flag_hold_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		irq_stat_q[0] && !(wr_stat && i_wdata[0]) |=> irq_stat_q[0]
	) else $error("first flag dropped without a clear");

	// the first flag never rises without an underflow
	flag_quiet_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		!irq_stat_q[0] && !uf0 |=> !irq_stat_q[0]
	) else $error("first flag rose without an underflow");

	// a raised second flag stays up until software clears it
	flag1_hold_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		irq_stat_q[1] && !(wr_stat && i_wdata[1]) |=> irq_stat_q[1]
	) else $error("second flag dropped without a clear");

	// the second flag never rises without a second underflow
	flag1_quiet_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		!irq_stat_q[1] && !uf1 |=> !irq_stat_q[1]
	) else $error("second flag rose without an underflow");

	// the event counter can only underflow on a first-timer underflow
	event_only_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		mode_event && uf1 |-> uf0
	) else $error("event counter underflowed on its own");

	// in periodic mode the second timer counts every clock
	step1_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		mode_periodic && run1 && (count1 != '0) |=> count1 == $past(count1_dec)
	) else $error("second timer did not decrement");

	// an armed but idle one-shot holds its count and keeps the pin low
	shot_idle_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		mode_oneshot && run1 && !busy_q && !trigger1
		|=> $stable(count1) && !o_second_timer_pulse_out
	) else $error("idle one-shot moved");

	// a shot in flight counts down and ignores a fresh trigger
	shot_run_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		busy_q && run1 && mode_oneshot && (count1 != '0)
		|=> o_second_timer_pulse_out && (count1 == $past(count1_dec))
	) else $error("one-shot stalled or restarted");

	// dropping the start flag or leaving the mode cuts a shot short
	shot_abort_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		busy_q && (!run1 || !mode_oneshot) |=> !o_second_timer_pulse_out
	) else $error("one-shot survived an abort");

endmodule // cpt_timer_pair

// file: verif/cpt_timer_pair_tb.sv
`timescale 1ns/1ps
module testbench;
	import cpt_pkg::*;

	// ----------------------------------------
	// signals and bookkeeping
	// ----------------------------------------
	logic i_clock = 1'b0;
	logic i_resetn = 1'b0;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [31:0] i_wdata = '0;
	logic i_write = 1'b0;
	logic i_read = 1'b0;
	logic [31:0] o_rdata;
	logic o_irq;
	logic o_second_timer_pulse_out;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [31:0] exp_q[$];
	logic rd_d = 1'b0;

	cpt_timer_pair #(.WIDTH(16)) u_dut (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_write(i_write),
		.i_read(i_read),
		.o_rdata(o_rdata),
		.o_irq(o_irq),
		.o_second_timer_pulse_out(o_second_timer_pulse_out)
	);

	// 100 MHz clock
	always #5 i_clock = ~i_clock;

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			fails++;
			$display("BAD %0t: seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// read data stand only in the cycle after the strobe, so compare exactly there
	always @(posedge i_clock) begin
		rd_d <= i_read;
		if (rd_d)
			chk(o_rdata, exp_q.pop_front());
	end

	// a hang costs one mismatch and ends the run through the common report
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			fails++;
			end_sim();
		end
	end

	// ----------------------------------------
	// register bus master
	// ----------------------------------------
	// one idle cycle between strobes keeps every assignment on its own edge
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_write <= 1'b1;
		@(posedge i_clock);
		i_write <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] want);
		@(posedge i_clock);
		i_addr <= a;
		i_read <= 1'b1;
		exp_q.push_back(want);
		@(posedge i_clock);
		i_read <= 1'b0;
	endtask

	// cycles between two interrupt rises; the status bit is cleared in between
	task automatic irq_period(input logic [31:0] bits, output int p);
		int n;
		int t0;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_irq !== 1'b1 && n < 4000);
		t0 = cyc;
		wr(CPT_IRQ_STAT_OFS, bits);
		do begin
			@(posedge i_clock);
			n++;
		end while (o_irq !== 1'b1 && n < 8000);
		p = cyc - t0;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int r0;
		int r1;
		int p;
		int hi;
		int lo;
		void'($urandom(32'hC4E4B46C));
		repeat (8) @(posedge i_clock);
		i_resetn <= 1'b1;
		// reset state, unmapped and read-only places
		rd(CPT_CTRL_OFS, 32'h0);
		rd(CPT_RELOAD0_OFS, 32'h3E7F);
		rd(CPT_RELOAD1_OFS, 32'h3E7);
		rd(CPT_COUNT0_OFS, 32'h3E7F);
		rd(CPT_IRQ_STAT_OFS, 32'h0);
		wr(8'h20, 32'hFFFFFFFF);
		rd(8'h20, 32'h0);
		wr(CPT_COUNT0_OFS, 32'h5);
		rd(CPT_COUNT0_OFS, 32'h3E7F);
		r1 = $urandom_range(16'hFFFF, 0);
		wr(CPT_RELOAD1_OFS, 32'hABCD0000 | r1);
		rd(CPT_RELOAD1_OFS, 32'(r1));
		// periodic first timer, interrupt masked then unmasked
		r0 = $urandom_range(20, 8);
		wr(CPT_RELOAD0_OFS, 32'(r0));
		wr(CPT_IRQ_MASK_OFS, 32'h1);
		wr(CPT_CTRL_OFS, 32'h1);
		irq_period(32'h1, p);
		chk(32'(p), 32'(r0 + 1));
		wr(CPT_IRQ_MASK_OFS, 32'h0);
		repeat (r0 + 2) @(posedge i_clock);
		#1 chk(32'(o_irq), 32'h0);
		rd(CPT_IRQ_STAT_OFS, 32'h1);
		wr(CPT_IRQ_MASK_OFS, 32'h1);
		#1 chk(32'(o_irq), 32'h1);
		// chained prescaler and event counting second timer
		wr(CPT_CTRL_OFS, 32'h0);
		r0 = $urandom_range(9, 3);
		r1 = $urandom_range(6, 2);
		wr(CPT_RELOAD0_OFS, 32'(r0));
		wr(CPT_RELOAD1_OFS, 32'(r1));
		wr(CPT_IRQ_STAT_OFS, 32'h3);
		wr(CPT_IRQ_MASK_OFS, 32'h2);
		wr(CPT_CTRL_OFS, 32'h7);
		irq_period(32'h2, p);
		chk(32'(p), 32'((r0 + 1) * (r1 + 1)));
		// pwm: period from the first timer, high time from the one-shot
		wr(CPT_CTRL_OFS, 32'h0);
		r0 = $urandom_range(40, 20);
		r1 = $urandom_range(15, 1);
		wr(CPT_RELOAD0_OFS, 32'(r0));
		wr(CPT_RELOAD1_OFS, 32'(r1));
		wr(CPT_IRQ_STAT_OFS, 32'h3);
		wr(CPT_IRQ_MASK_OFS, 32'h0);
		wr(CPT_CTRL_OFS, 32'hB);
		p = 0;
		do begin
			@(posedge i_clock);
			p++;
		end while (o_second_timer_pulse_out !== 1'b1 && p < 200);
		hi = 0;
		lo = 0;
		while (o_second_timer_pulse_out === 1'b1 && hi < 200) begin
			hi++;
			@(posedge i_clock);
		end
		while (o_second_timer_pulse_out === 1'b0 && lo < 200) begin
			lo++;
			@(posedge i_clock);
		end
		chk(32'(hi), 32'(r1 + 1));
		chk(32'(hi + lo), 32'(r0 + 1));
		rd(CPT_IRQ_STAT_OFS, 32'h3);
		// four cycles into the second shot; a short shot has already reloaded and stopped
		rd(CPT_COUNT1_OFS, 32'(r1 >= 4 ? r1 - 4 : r1));
		// second timer alone; the reserved mode code counts as periodic
		wr(CPT_CTRL_OFS, 32'h0);
		wr(CPT_RELOAD1_OFS, 32'(r0));
		wr(CPT_IRQ_STAT_OFS, 32'h3);
		wr(CPT_IRQ_MASK_OFS, 32'h2);
		wr(CPT_CTRL_OFS, 32'hE);
		rd(CPT_STATUS_OFS, 32'h0);
		irq_period(32'h2, p);
		chk(32'(p), 32'(r0 + 1));
		rd(CPT_IRQ_MASK_OFS, 32'h2);
		repeat (4) @(posedge i_clock);
		end_sim();
	end

endmodule // testbench
